// *** design/serial_link_mode_param_config.sv ***
// Purpose: receive-side link parameter bank for the high-rate modes
// Assumes: registers reached only over the serial register port
// Notes: stored values take effect when the lane enable mask is written
//
// Overview of operation
// - bit 7 of 0x453 enables descrambling
// - 0x453 low bits: lanes per link minus one
// - 0x454 holds octets per frame minus one
// - 0x476 holds octets per frame directly
// - 0x455 low bits: frames per multiframe minus one
// - 0x456 must be zero, one converter
// - 0x457: control bits zero, resolution 16
// - 0x458: subclass, 16 bits per sample
// - 0x459: version one, samples minus one
// - 0x45a: high density flag, control words zero
// - lane_deskew_mask deskew mask, one bit per lane
// - lane_enable_mask lane enable mask, flagged lanes capture
// - 0x030 flags illegal delay, combination, K, subclass
`timescale 1ns/1ps
`include "link_cfg_consts.svh"
module serial_link_mode_param_config (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial register port
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   // multiframe clock delay from the timing logic
   input wire logic [4:0] lmfc_delay,
   // applied parameters to the receiver
   output logic descramble_en,
   output logic [4:0] lane_count_m1,
   output logic [7:0] octets_m1,
   output logic [4:0] frames_m1,
   output logic [2:0] subclass,
   output logic [4:0] samples_m1,
   output logic high_density,
   output logic [7:0] deskew_en,
   output logic [7:0] lane_capture_en,
   output link_cfg_pkg::link_mode_e link_mode
);
   reg_access_if bus ();

   logic [7:0] lane_scr_r;
   logic [7:0] oct_m1_r;
   logic [7:0] frames_r;
   logic [7:0] conv_r;
   logic [7:0] cs_res_r;
   logic [7:0] sub_np_r;
   logic [7:0] ver_s_r;
   logic [7:0] density_and_control_words_r;
   logic [7:0] deskew_r;
   logic [7:0] oct_dir_r;
   logic [7:0] lane_en_r;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] rdata_nxt;
   logic descramble_r;
   logic [4:0] lane_count_r;
   logic [7:0] octets_r;
   logic [4:0] frames_m1_r;
   logic [2:0] subclass_r;
   logic [4:0] samples_r;
   logic hd_r;
   logic [7:0] deskew_en_r;
   logic [7:0] capture_r;
   link_cfg_pkg::link_mode_e mode_r;
   logic apply;
   logic combo_ok;
   logic k_ok;

   spi_reg_port u_port (
      .clk(clk),
      .reset(reset),
      .sclk(spi_sclk),
      .cs_n(spi_cs_n),
      .sdi(spi_sdi),
      .sdo(spi_sdo),
      .sdo_oe_n(spi_sdo_oe_n),
      .bus(bus.port)
   );

   // writing the lane enable mask commits the stored set
   assign apply = bus.wr_stb && bus.addr == `ADDR_LANE_EN;

   // parameter registers hold until rewritten or reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lane_scr_r <= `RST_LANE_SCR;
         oct_m1_r <= `RST_OCT_M1;
         frames_r <= `RST_FRAMES_MF;
         conv_r <= `RST_CONVERTERS;
         cs_res_r <= `RST_CS_RES;
         sub_np_r <= `RST_SUBCLASS_NP;
         ver_s_r <= `RST_VER_SAMPLES;
         density_and_control_words_r <= `RST_DENSITY_AND_CONTROL_WORDS;
         deskew_r <= `RST_DESKEW;
         oct_dir_r <= `RST_OCT_DIRECT;
         lane_en_r <= `RST_LANE_EN;
      end else if (bus.wr_stb) begin
         case (bus.addr)
            `ADDR_LANE_SCR: lane_scr_r <= bus.wdata;
            `ADDR_OCT_M1: oct_m1_r <= bus.wdata;
            `ADDR_FRAMES_MF: frames_r <= bus.wdata;
            `ADDR_CONVERTERS: conv_r <= bus.wdata;
            `ADDR_CS_RES: cs_res_r <= bus.wdata;
            `ADDR_SUBCLASS_NP: sub_np_r <= bus.wdata;
            `ADDR_VER_SAMPLES: ver_s_r <= bus.wdata;
            `ADDR_DENSITY_AND_CONTROL_WORDS: density_and_control_words_r <= bus.wdata;
            `ADDR_DESKEW: deskew_r <= bus.wdata;
            `ADDR_OCT_DIRECT: oct_dir_r <= bus.wdata;
            `ADDR_LANE_EN: lane_en_r <= bus.wdata;
            default: ;
         endcase
      end
   end

   // frames per multiframe: 32 always, 16 only with two octets
   always_comb begin
      k_ok = frames_r[4:0] == `VAL_K32_M1 ||
             (frames_r[4:0] == `VAL_K16_M1 && oct_m1_r == 8'h01);
   end

   // receive side counts are half the transmitter's true counts
   always_comb begin
      combo_ok = 1'b0;
      if (lane_scr_r[4:0] == 5'h03 && oct_m1_r == 8'h00 && ver_s_r[4:0] == 5'h01 && density_and_control_words_r[7])
         combo_ok = 1'b1;
      if (lane_scr_r[4:0] == 5'h01 && oct_m1_r == 8'h00 && ver_s_r[4:0] == 5'h00 && density_and_control_words_r[7])
         combo_ok = 1'b1;
      if (lane_scr_r[4:0] == 5'h00 && oct_m1_r == 8'h01 && ver_s_r[4:0] == 5'h00 && !density_and_control_words_r[7])
         combo_ok = 1'b1;
      if (conv_r != 8'h00)
         combo_ok = 1'b0;
      if (oct_dir_r != oct_m1_r + 8'h01)
         combo_ok = 1'b0;
      if (cs_res_r[7:6] != 2'b00 || cs_res_r[4:0] != `VAL_RES_M1)
         combo_ok = 1'b0;
      if (sub_np_r[4:0] != `VAL_NP_M1 || ver_s_r[7:5] != `VAL_VERSION)
         combo_ok = 1'b0;
      if (density_and_control_words_r[4:0] != 5'h00)
         combo_ok = 1'b0;
   end

   // live checks, visible one cycle after the offending value
   always_comb begin
      status_nxt = 8'h00;
      status_nxt[`BIT_ERR_LMFC] = lmfc_delay > frames_r[4:0];
      status_nxt[`BIT_ERR_COMBO] = !combo_ok;
      status_nxt[`BIT_ERR_K] = !k_ok;
      status_nxt[`BIT_ERR_SUBCLASS] = sub_np_r[7:5] > `VAL_SUBCLASS_MAX;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         status_r <= 8'h00;
      else
         status_r <= status_nxt;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      case (bus.addr)
         `ADDR_STATUS: rdata_nxt = status_r;
         `ADDR_LANE_SCR: rdata_nxt = lane_scr_r;
         `ADDR_OCT_M1: rdata_nxt = oct_m1_r;
         `ADDR_FRAMES_MF: rdata_nxt = frames_r;
         `ADDR_CONVERTERS: rdata_nxt = conv_r;
         `ADDR_CS_RES: rdata_nxt = cs_res_r;
         `ADDR_SUBCLASS_NP: rdata_nxt = sub_np_r;
         `ADDR_VER_SAMPLES: rdata_nxt = ver_s_r;
         `ADDR_DENSITY_AND_CONTROL_WORDS: rdata_nxt = density_and_control_words_r;
         `ADDR_DESKEW: rdata_nxt = deskew_r;
         `ADDR_OCT_DIRECT: rdata_nxt = oct_dir_r;
         `ADDR_LANE_EN: rdata_nxt = lane_en_r;
         default: rdata_nxt = 8'h00;
      endcase
   end
   assign bus.rdata = rdata_nxt;

   // applied set changes only at commit, so the receiver never sees half a config
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         descramble_r <= 1'b0;
         lane_count_r <= 5'h00;
         octets_r <= 8'h00;
         frames_m1_r <= 5'h00;
         subclass_r <= 3'h0;
         samples_r <= 5'h00;
         hd_r <= 1'b0;
         deskew_en_r <= 8'h00;
         capture_r <= 8'h00;
      end else if (apply) begin
         descramble_r <= lane_scr_r[`BIT_SCRAMBLE];
         lane_count_r <= lane_scr_r[4:0];
         octets_r <= oct_m1_r;
         frames_m1_r <= frames_r[4:0];
         subclass_r <= sub_np_r[7:5];
         samples_r <= ver_s_r[4:0];
         hd_r <= density_and_control_words_r[`BIT_HIGH_DENSITY];
         deskew_en_r <= deskew_r;
         capture_r <= bus.wdata;
      end
   end

   // mode recognised from the committed lane enable mask
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         mode_r <= link_cfg_pkg::MODE_UNKNOWN;
      else if (apply) begin
         case (bus.wdata)
            `MASK_MODE11: mode_r <= link_cfg_pkg::MODE_11;
            `MASK_MODE12: mode_r <= link_cfg_pkg::MODE_12;
            `MASK_MODE13: mode_r <= link_cfg_pkg::MODE_13;
            default: mode_r <= link_cfg_pkg::MODE_UNKNOWN;
         endcase
      end
   end

   assign descramble_en = descramble_r;
   assign lane_count_m1 = lane_count_r;
   assign octets_m1 = octets_r;
   assign frames_m1 = frames_m1_r;
   assign subclass = subclass_r;
   assign samples_m1 = samples_r;
   assign high_density = hd_r;
   assign deskew_en = deskew_en_r;
   assign lane_capture_en = capture_r;
   assign link_mode = mode_r;

   // checks on the committed set, the status flags and the stored lane register
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_commit;
      bus.wr_stb && bus.addr == `ADDR_LANE_EN;
   endsequence

   sequence s_no_commit2;
      !apply [*2];
   endsequence

   property p_scramble;
      s_commit |=> descramble_en == $past(lane_scr_r[`BIT_SCRAMBLE]);
   endproperty
   a_scramble: assert property (p_scramble) else $error("descramble not applied");

   property p_lanes;
      s_commit |=> lane_count_m1 == $past(lane_scr_r[4:0]) && octets_m1 == $past(oct_m1_r);
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane or octet count not applied");

   property p_octets_direct;
      (oct_dir_r != oct_m1_r + 8'h01) |=> status_r[`BIT_ERR_COMBO];
   endproperty
   a_octets_direct: assert property (p_octets_direct) else $error("octet mismatch not flagged");

   property p_frames;
      (frames_r[4:0] != `VAL_K32_M1 && frames_r[4:0] != `VAL_K16_M1) |=> status_r[`BIT_ERR_K];
   endproperty
   a_frames: assert property (p_frames) else $error("illegal frames not flagged");

   property p_converters;
      (conv_r != 8'h00) |=> status_r[`BIT_ERR_COMBO];
   endproperty
   a_converters: assert property (p_converters) else $error("converter count not flagged");

   property p_resolution;
      (cs_res_r[4:0] != `VAL_RES_M1) |=> status_r[`BIT_ERR_COMBO];
   endproperty
   a_resolution: assert property (p_resolution) else $error("resolution not flagged");

   property p_subclass;
      (sub_np_r[7:5] > `VAL_SUBCLASS_MAX) |=> status_r[`BIT_ERR_SUBCLASS];
   endproperty
   a_subclass: assert property (p_subclass) else $error("subclass not flagged");

   property p_density;
      s_commit |=> high_density == $past(density_and_control_words_r[`BIT_HIGH_DENSITY]) && samples_m1 == $past(ver_s_r[4:0]);
   endproperty
   a_density: assert property (p_density) else $error("density or samples not applied");

   property p_deskew;
      s_commit |=> deskew_en == $past(deskew_r);
   endproperty
   a_deskew: assert property (p_deskew) else $error("deskew mask not applied");

   property p_capture;
      s_commit ##1 s_no_commit2 |-> lane_capture_en == $past(lane_capture_en);
   endproperty
   a_capture: assert property (p_capture) else $error("capture mask moved without commit");

   property p_lmfc;
      (lmfc_delay > frames_r[4:0]) |=> status_r[`BIT_ERR_LMFC];
   endproperty
   a_lmfc: assert property (p_lmfc) else $error("delay error not flagged");

   property p_hold;
      !(bus.wr_stb && bus.addr == `ADDR_LANE_SCR) |=> $stable(lane_scr_r);
   endproperty
   a_hold: assert property (p_hold) else $error("lane register changed unwritten");
endmodule : serial_link_mode_param_config

// *** inc/link_cfg_consts.svh ***
// Purpose: offsets, field positions and reset values of the link parameter bank
// Assumes: 15-bit register addresses, 8-bit register data
// Notes: reset values select the four-lane high-rate mode with scrambling off
`ifndef LINK_CFG_CONSTS_SVH
`define LINK_CFG_CONSTS_SVH

// register offsets
`define ADDR_STATUS        15'h030
`define ADDR_LANE_SCR      15'h453
`define ADDR_OCT_M1        15'h454
`define ADDR_FRAMES_MF     15'h455
`define ADDR_CONVERTERS    15'h456
`define ADDR_CS_RES        15'h457
`define ADDR_SUBCLASS_NP   15'h458
`define ADDR_VER_SAMPLES   15'h459
`define ADDR_DENSITY_AND_CONTROL_WORDS         15'h45a
`define ADDR_DESKEW        15'h46c
`define ADDR_OCT_DIRECT    15'h476
`define ADDR_LANE_EN       15'h47d

// field positions
`define BIT_SCRAMBLE       7
`define BIT_HIGH_DENSITY   7
`define BIT_ERR_LMFC       5
`define BIT_ERR_COMBO      3
`define BIT_ERR_K          2
`define BIT_ERR_SUBCLASS   1

// expected field values
`define VAL_RES_M1         5'h0f
`define VAL_NP_M1          5'h0f
`define VAL_VERSION        3'h1
`define VAL_SUBCLASS_MAX   3'h1
`define VAL_K16_M1         5'h0f
`define VAL_K32_M1         5'h1f
`define MASK_MODE11        8'hff
`define MASK_MODE12        8'h33
`define MASK_MODE13        8'h11

// reset values
`define RST_LANE_SCR       8'h03
`define RST_OCT_M1         8'h00
`define RST_FRAMES_MF      8'h1f
`define RST_CONVERTERS     8'h00
`define RST_CS_RES         8'h0f
`define RST_SUBCLASS_NP    8'h0f
`define RST_VER_SAMPLES    8'h21
`define RST_DENSITY_AND_CONTROL_WORDS          8'h80
`define RST_DESKEW         8'h00
`define RST_OCT_DIRECT     8'h01
`define RST_LANE_EN        8'h00

`endif

// *** inc/link_cfg_pkg.sv ***
// Purpose: types shared by the link parameter bank
// Assumes: nothing
// Notes: mode codes are the detected receive-side mode
package link_cfg_pkg;
   typedef enum logic [1:0] {
      MODE_UNKNOWN = 2'b00,
      MODE_11 = 2'b01,
      MODE_12 = 2'b10,
      MODE_13 = 2'b11
   } link_mode_e;
endpackage : link_cfg_pkg

// *** inc/reg_access_if.sv ***
// Purpose: register access strobes between the serial port and the bank
// Assumes: one clock, strobes one cycle long
// Notes: rdata answers combinationally during rd_stb
`timescale 1ns/1ps
interface reg_access_if;
   logic wr_stb;
   logic rd_stb;
   logic [14:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

// *** design/spi_reg_port.sv ***
// Purpose: serial register port, one 24-bit frame per access
// Assumes: sclk at most a third of clk rate, pins synchronous to clk
// Notes: frame is r/w bit, 15 address bits, 8 data bits, msb first
`timescale 1ns/1ps
module spi_reg_port (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe_n,
   // register side
   reg_access_if.port bus
);
   logic sclk_q_r;
   logic [4:0] cnt_r;
   logic [22:0] in_sh_r;
   logic rw_r;
   logic [7:0] out_sh_r;
   logic sdo_r;
   logic oe_n_r;
   logic rd_stb_r;
   logic wr_stb_r;
   logic [14:0] addr_r;
   logic [7:0] wdata_r;
   logic rise;
   logic fall;

   // edges of the sampled serial clock
   assign rise = ~cs_n & sclk & ~sclk_q_r;
   assign fall = ~cs_n & ~sclk & sclk_q_r;

   // bit counter stops at the frame end; extra bits are ignored
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclk_q_r <= 1'b0;
         cnt_r <= 5'h00;
      end else begin
         sclk_q_r <= sclk;
         if (cs_n)
            cnt_r <= 5'h00;
         else if (rise && cnt_r != 5'h18)
            cnt_r <= cnt_r + 5'h01;
      end
   end

   // shift in header and data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         in_sh_r <= 23'h000000;
         rw_r <= 1'b0;
      end else if (rise && cnt_r != 5'h18) begin
         in_sh_r <= {in_sh_r[21:0], sdi};
         if (cnt_r == 5'h00)
            rw_r <= sdi;
      end
   end

   // strobes registered so the bank sees clean pulses
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_stb_r <= 1'b0;
         wr_stb_r <= 1'b0;
         addr_r <= 15'h0000;
         wdata_r <= 8'h00;
      end else begin
         rd_stb_r <= rise && cnt_r == 5'h0f && rw_r;
         wr_stb_r <= rise && cnt_r == 5'h17 && !rw_r;
         if (rise && cnt_r == 5'h0f)
            addr_r <= {in_sh_r[13:0], sdi};
         if (rise && cnt_r == 5'h17)
            wdata_r <= {in_sh_r[6:0], sdi};
      end
   end

   // read data leaves on falling edges after the header
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_sh_r <= 8'h00;
         sdo_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         if (rd_stb_r)
            out_sh_r <= bus.rdata;
         else if (fall && rw_r && cnt_r >= 5'h10 && cnt_r != 5'h18)
            out_sh_r <= {out_sh_r[6:0], 1'b0};
         if (fall && rw_r && cnt_r >= 5'h10 && cnt_r != 5'h18)
            sdo_r <= out_sh_r[7];
         if (cs_n)
            oe_n_r <= 1'b1;
         else if (fall && rw_r && cnt_r >= 5'h10)
            oe_n_r <= 1'b0;
      end
   end

   assign bus.rd_stb = rd_stb_r;
   assign bus.wr_stb = wr_stb_r;
   assign bus.addr = addr_r;
   assign bus.wdata = wdata_r;
   assign sdo = sdo_r;
   assign sdo_oe_n = oe_n_r;
endmodule : spi_reg_port

// *** dv/spi_host.sv ***
// Purpose: serial register host at the far side of the register port
// Assumes: sclk phases of four clk cycles, pins changed at clk falling edge
// Notes: a released sdo reads back inverted, so a missing drive never matches
`timescale 1ns/1ps
module spi_host (
   // clock
   input wire logic clk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe_n
);
   // idle pins
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // one whole 24-bit frame; read bits taken late in the low phase, well after the fall
   task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [23:0] fr;
      fr = {rw, a, d};
      q = 8'h00;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = fr[i];
         repeat (4) @(negedge clk);
         if (i < 8) q[i] = (sdo_oe_n === 1'b0) ? sdo : ~sdo;
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      cs_n = 1'b1;
      repeat (3) @(negedge clk); // gap between frames
   endtask : xfer
endmodule : spi_host

// *** dv/serial_link_mode_param_config_bench.sv ***
// Purpose: self-checking bench of the link parameter bank
// Assumes: registers reached only through the serial host model
// Notes: shadow array of stored values gives the register, status and applied-set expectations
`timescale 1ns/1ps
`include "link_cfg_consts.svh"
module serial_link_mode_param_config_bench;
   logic clk, reset, sclk, cs_n, sdi, sdo, sdo_oe_n, descramble_en, high_density;
   logic [4:0] lmfc, lane_count_m1, frames_m1, samples_m1;
   logic [7:0] octets_m1, deskew_en, lane_capture_en, rnd, k, q;
   logic [2:0] subclass;
   link_cfg_pkg::link_mode_e link_mode;
   logic [7:0] sh [logic [14:0]];
   logic [45:0] ap;
   int bad_count, num_checks;
   localparam logic [7:0] mk [3] = '{8'hff, 8'h33, 8'h11};
   wire logic [45:0] outs = {descramble_en, lane_count_m1, octets_m1, frames_m1, subclass, samples_m1,
      high_density, deskew_en, lane_capture_en, link_mode};

   serial_link_mode_param_config i_serial_link_mode_param_config (.clk(clk), .reset(reset),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n),
      .lmfc_delay(lmfc), .descramble_en(descramble_en), .lane_count_m1(lane_count_m1),
      .octets_m1(octets_m1), .frames_m1(frames_m1), .subclass(subclass), .samples_m1(samples_m1),
      .high_density(high_density), .deskew_en(deskew_en), .lane_capture_en(lane_capture_en),
      .link_mode(link_mode));
   spi_host i_spi_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   function automatic logic [1:0] mode_of(input logic [7:0] m);
      return (m == 8'hff) ? 2'h1 : (m == 8'h33) ? 2'h2 : (m == 8'h11) ? 2'h3 : 2'h0;
   endfunction : mode_of

   // live status from the stored values and the delay input
   function automatic logic [7:0] status_exp();
      logic ok;
      logic [18:0] t;
      t = {sh[`ADDR_LANE_SCR][4:0], sh[`ADDR_OCT_M1], sh[`ADDR_VER_SAMPLES][4:0], sh[`ADDR_DENSITY_AND_CONTROL_WORDS][7]};
      ok = (t == {5'h3, 8'h0, 5'h1, 1'b1} || t == {5'h1, 8'h0, 5'h0, 1'b1} || t == {5'h0, 8'h1, 5'h0, 1'b0})
         && sh[`ADDR_CONVERTERS] == 8'h00 && sh[`ADDR_OCT_DIRECT] == sh[`ADDR_OCT_M1] + 8'h01
         && sh[`ADDR_CS_RES][7:6] == 2'h0 && sh[`ADDR_CS_RES][4:0] == 5'h0f
         && sh[`ADDR_SUBCLASS_NP][4:0] == 5'h0f && sh[`ADDR_VER_SAMPLES][7:5] == 3'h1
         && sh[`ADDR_DENSITY_AND_CONTROL_WORDS][4:0] == 5'h00;
      k = sh[`ADDR_FRAMES_MF] & 8'h1f;
      return {2'h0, lmfc > k[4:0], 1'b0, !ok, !(k == 8'h1f || (k == 8'h0f && sh[`ADDR_OCT_M1] == 8'h01)),
         sh[`ADDR_SUBCLASS_NP][7:5] > 3'h1, 1'b0};
   endfunction : status_exp

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // a write to the lane enable mask commits every stored value except 0x456, 0x457 and 0x476 at once
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      i_spi_host.xfer(1'b0, a, d, q);
      if (sh.exists(a)) sh[a] = d;
      if (a == `ADDR_LANE_EN) ap = {sh[`ADDR_LANE_SCR][7], sh[`ADDR_LANE_SCR][4:0], sh[`ADDR_OCT_M1],
         sh[`ADDR_FRAMES_MF][4:0], sh[`ADDR_SUBCLASS_NP][7:5], sh[`ADDR_VER_SAMPLES][4:0], sh[`ADDR_DENSITY_AND_CONTROL_WORDS][7],
         sh[`ADDR_DESKEW], d, mode_of(d)};
   endtask : wr

   task automatic rd(input logic [14:0] a);
      i_spi_host.xfer(1'b1, a, 8'h00, q);
      check($sformatf("reg %h", a), q, (a == `ADDR_STATUS) ? status_exp() : sh.exists(a) ? sh[a] : 8'h00);
   endtask : rd

   task automatic rd_all();
      foreach (sh[a]) rd(a);
      rd(`ADDR_STATUS);
   endtask : rd_all

   // shadow of the stored registers as reset leaves them; nothing applied yet
   task automatic sh_init();
      ap = '0;
      sh[`ADDR_LANE_SCR] = `RST_LANE_SCR;
      sh[`ADDR_OCT_M1] = `RST_OCT_M1;
      sh[`ADDR_FRAMES_MF] = `RST_FRAMES_MF;
      sh[`ADDR_CONVERTERS] = `RST_CONVERTERS;
      sh[`ADDR_CS_RES] = `RST_CS_RES;
      sh[`ADDR_SUBCLASS_NP] = `RST_SUBCLASS_NP;
      sh[`ADDR_VER_SAMPLES] = `RST_VER_SAMPLES;
      sh[`ADDR_DENSITY_AND_CONTROL_WORDS] = `RST_DENSITY_AND_CONTROL_WORDS;
      sh[`ADDR_DESKEW] = `RST_DESKEW;
      sh[`ADDR_OCT_DIRECT] = `RST_OCT_DIRECT;
      sh[`ADDR_LANE_EN] = `RST_LANE_EN;
   endtask : sh_init

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog at twice the roughly 30000 cycles of traffic
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      test_done();
   end

   initial begin
      reset = 1'b1;
      lmfc = 5'h00;
      rnd = 8'h0e;
      sh_init();
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      check("applied", outs, ap);
      check("sdo_oe_n", sdo_oe_n, 1'b1);
      rd_all();
      $display("test reset done");
      // each high-rate mode, host order: link select, parameters, deskew, then enable
      for (int m = 0; m < 3; m++) begin
         rnd = lfsr(rnd);
         k = (m == 2 && rnd[1]) ? 8'h0f : 8'h1f;
         wr(15'h300, 8'h00);
         wr(`ADDR_LANE_SCR, {rnd[0], 2'h0, mode_of(mk[m]) == 2'h1 ? 5'h3 : m == 1 ? 5'h1 : 5'h0});
         wr(`ADDR_OCT_M1, (m == 2) ? 8'h01 : 8'h00);
         wr(`ADDR_OCT_DIRECT, (m == 2) ? 8'h02 : 8'h01);
         wr(`ADDR_FRAMES_MF, k);
         wr(`ADDR_CONVERTERS, 8'h00);
         wr(`ADDR_CS_RES, 8'h0f);
         wr(`ADDR_SUBCLASS_NP, {2'h0, rnd[2], 5'h0f});
         wr(`ADDR_VER_SAMPLES, (m == 0) ? 8'h21 : 8'h20);
         wr(`ADDR_DENSITY_AND_CONTROL_WORDS, (m == 2) ? 8'h00 : 8'h80);
         wr(`ADDR_DESKEW, mk[m]);
         check("held", outs, ap);
         wr(`ADDR_LANE_EN, mk[m]);
         check("applied", outs, ap);
         check("tx lanes", 2 * (lane_count_m1 + 1), 8 >> m);
         lmfc = rnd[7:3] & k[4:0];
         check("legal", status_exp(), 8'h00);
         rd_all();
         $display("test mode %0d done", m + 11);
      end
      // random and boundary faults on the status flags; no commit in between
      for (int i = 0; i < 10; i++) begin
         rnd = lfsr(rnd);
         wr(`ADDR_FRAMES_MF, (i == 1) ? 8'h0f : {3'h0, rnd[4:0]});
         wr(`ADDR_SUBCLASS_NP, {rnd[7:5], 5'h0f});
         wr(`ADDR_CONVERTERS, {7'h0, rnd[3]});
         wr(`ADDR_STATUS, 8'hff);
         lmfc = (i == 0) ? sh[`ADDR_FRAMES_MF][4:0] + 5'h1 : rnd[6:2];
         rd(`ADDR_STATUS);
         check("held", outs, ap);
      end
      rd(15'h123);
      wr(`ADDR_LANE_EN, 8'h00);
      check("applied", outs, ap);
      $display("test status done");
      // reset in mid-run, host idle: stored set back to reset values, applied set cleared
      reset = 1'b1;
      sh_init();
      repeat (2) @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      check("applied", outs, ap);
      check("sdo_oe_n", sdo_oe_n, 1'b1);
      rd_all();
      $display("test mid reset done");
      test_done();
   end
endmodule : serial_link_mode_param_config_bench
